// *** scrr_defines.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef SCRR_DEFINES_SVH
`define SCRR_DEFINES_SVH
`define SCRR_ADDR_CFG_A        15'h0000
`define SCRR_ADDR_CFG_B        15'h0001
`define SCRR_ADDR_PWR          15'h0002
`define SCRR_ADDR_CH_SEL       15'h0008
`define SCRR_BIT_SRST          0
`define SCRR_BIT_SRST_M        7
`define SCRR_BIT_LSBF          1
`define SCRR_BIT_LSBF_M        6
`define SCRR_BIT_ASC           2
`define SCRR_BIT_ASC_M         5
`define SCRR_BIT_DP_RST        1
`define SCRR_RST_CFG           8'h00
`define SCRR_RST_PWR           2'h0
`define SCRR_RST_CH_SEL        2'h3
`define SCRR_PWR_NORMAL        2'h0
`define SCRR_PWR_STANDBY       2'h2
`define SCRR_PWR_DOWN          2'h3
`define SCRR_BOOT_NS           5000000
`define SCRR_CLK_NS            8
// boot must end within the wait, so round down
`define SCRR_BOOT_CYC          (`SCRR_BOOT_NS / `SCRR_CLK_NS)
`endif

// *** scrr_pkg.sv ***
// types shared by the configuration register bank
package scrr_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } scrr_req_t;

  typedef struct packed {
    logic clk_en;
    logic dp_rst;
    logic link_en;
  } scrr_ch_ctl_t;

  typedef enum logic [1:0] {
    SCRR_RUN,
    SCRR_BOOT
  } scrr_state_t;
endpackage

// *** scrr_chan_pwr.sv ***
// per-channel power-mode register and its decoded controls
`timescale 1ns/100ps
`default_nettype none
`include "scrr_defines.svh"
module scrr_chan_pwr
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic                  clr,
  // write port
  input  wire logic                  we,
  input  wire logic [1:0]            wdata,
  // state
  output logic [1:0]                 mode_q,
  output var scrr_pkg::scrr_ch_ctl_t ctl
);
  always_ff @(posedge clock)
  begin
    if (srst || clr)
      mode_q <= `SCRR_RST_PWR;
    else if (we)
      mode_q <= wdata;
  end

  // unlisted code 01 is treated as normal operation
  always_comb
  begin
    ctl.clk_en  = 1'b1;
    ctl.dp_rst  = 1'b0;
    ctl.link_en = 1'b1;
    case (mode_q)
      `SCRR_PWR_STANDBY:
      begin
        ctl.clk_en = 1'b0;
      end
      `SCRR_PWR_DOWN:
      begin
        ctl.clk_en  = 1'b0;
        ctl.dp_rst  = 1'b1;
        ctl.link_en = 1'b0;
      end
      default:
      begin
        ctl.clk_en = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** scrr_regs.sv ***
// serial configuration, soft reset and channel power register bank
`timescale 1ns/100ps
`default_nettype none
`include "scrr_defines.svh"
module scrr_regs
#(
  parameter int unsigned BOOT_CYC = `SCRR_BOOT_CYC
)
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // register access from the serial frame decoder
  input  wire scrr_pkg::scrr_req_t   req,
  output logic [7:0]                 rdata_q,
  output logic                       rvalid_q,
  // serial port configuration
  output logic                       lsb_first,
  output logic                       addr_incr,
  output logic                       port_rst_q,
  output logic                       booting,
  // datapath control
  output logic                       dp_soft_rst_q,
  output var scrr_pkg::scrr_ch_ctl_t ch_a_ctl,
  output var scrr_pkg::scrr_ch_ctl_t ch_b_ctl
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]            cfg_a_q;     // {ascend, lsb first}
  logic [1:0]            ch_sel_q;
  logic [1:0]            pwr_a;
  logic [1:0]            pwr_b;
  logic [31:0]           boot_cnt_q;
  scrr_pkg::scrr_state_t state_q;
  logic                  wr_a;
  logic                  wr_b;
  logic                  wr_pwr;
  logic                  soft_rst;
  logic                  reload;

  assign wr_a   = req.wr && req.addr == `SCRR_ADDR_CFG_A;
  assign wr_b   = req.wr && req.addr == `SCRR_ADDR_CFG_B;
  assign wr_pwr = req.wr && req.addr == `SCRR_ADDR_PWR;
  // writing 0 to both reset bits does nothing
  assign soft_rst = wr_a && (req.wdata[`SCRR_BIT_SRST]
                    || req.wdata[`SCRR_BIT_SRST_M]);
  // clear on the reset write itself, so no stale mode outlives it
  assign reload = booting || soft_rst;

  // ----------------------------------------------------------------
  // soft reset and boot sequencing
  // ----------------------------------------------------------------
  // writes during boot are dropped; the host must honour the wait
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q    <= scrr_pkg::SCRR_BOOT;
      boot_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        scrr_pkg::SCRR_RUN:
        begin
          if (soft_rst)
          begin
            state_q    <= scrr_pkg::SCRR_BOOT;
            boot_cnt_q <= 32'h0000_0000;
          end
        end
        scrr_pkg::SCRR_BOOT:
        begin
          if (boot_cnt_q >= BOOT_CYC - 1)
            state_q <= scrr_pkg::SCRR_RUN;
          else
            boot_cnt_q <= boot_cnt_q + 32'h0000_0001;
        end
        default:
        begin
          state_q <= scrr_pkg::SCRR_RUN;
        end
      endcase
    end
  end

  assign booting = state_q == scrr_pkg::SCRR_BOOT;

  // one-cycle pulse; the reset bit itself never stores, so it self-clears
  always_ff @(posedge clock)
  begin
    if (srst)
      port_rst_q <= 1'b0;
    else
      port_rst_q <= soft_rst && !booting;
  end

  // ----------------------------------------------------------------
  // configuration A: bit order and address direction
  // ----------------------------------------------------------------
  // mirrored bits are ORed so either copy sets the mode
  always_ff @(posedge clock)
  begin
    if (srst || reload)
      cfg_a_q <= 2'(`SCRR_RST_CFG);
    else if (wr_a && !soft_rst)
    begin
      cfg_a_q[0] <= req.wdata[`SCRR_BIT_LSBF]
                    | req.wdata[`SCRR_BIT_LSBF_M];
      cfg_a_q[1] <= req.wdata[`SCRR_BIT_ASC]
                    | req.wdata[`SCRR_BIT_ASC_M];
    end
  end

  assign lsb_first = cfg_a_q[0];
  assign addr_incr = cfg_a_q[1];

  // ----------------------------------------------------------------
  // configuration B: datapath soft reset pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst || booting)
      dp_soft_rst_q <= 1'b0;
    else
      dp_soft_rst_q <= wr_b && req.wdata[`SCRR_BIT_DP_RST];
  end

  // ----------------------------------------------------------------
  // channel select and local power registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst || reload)
      ch_sel_q <= `SCRR_RST_CH_SEL;
    else if (req.wr && req.addr == `SCRR_ADDR_CH_SEL)
      ch_sel_q <= req.wdata[1:0];
  end

  scrr_chan_pwr u_pwr_a
  (
    .clock  (clock),
    .srst   (srst),
    .clr    (reload),
    .we     (wr_pwr && ch_sel_q[0] && !booting),
    .wdata  (req.wdata[1:0]),
    .mode_q (pwr_a),
    .ctl    (ch_a_ctl)
  );

  scrr_chan_pwr u_pwr_b
  (
    .clock  (clock),
    .srst   (srst),
    .clr    (reload),
    .we     (wr_pwr && ch_sel_q[1] && !booting),
    .wdata  (req.wdata[1:0]),
    .mode_q (pwr_b),
    .ctl    (ch_b_ctl)
  );

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= req.rd;
      if (req.rd)
      begin
        case (req.addr)
          `SCRR_ADDR_CFG_A:
            rdata_q <= {1'b0, cfg_a_q[0], cfg_a_q[1], 2'h0,
                        cfg_a_q[1], cfg_a_q[0], 1'b0};
          `SCRR_ADDR_PWR:
            rdata_q <= {6'h00, ch_sel_q[0] ? pwr_a : pwr_b};
          `SCRR_ADDR_CH_SEL:
            rdata_q <= {6'h00, ch_sel_q};
          default:
            rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_soft_rst_wr;
    !booting && soft_rst;
  endsequence

  property p_soft_rst_pulse;
    @(posedge clock) disable iff (srst)
      s_soft_rst_wr |=> port_rst_q && booting;
  endproperty
  a_soft_rst_pulse: assert property (p_soft_rst_pulse)
    else $error("soft reset write did not pulse port reset");

  property p_boot_defaults;
    @(posedge clock) disable iff (srst)
      s_soft_rst_wr |=> !lsb_first && !addr_incr && pwr_a == 2'h0;
  endproperty
  a_boot_defaults: assert property (p_boot_defaults)
    else $error("defaults not reloaded after soft reset");

  property p_lsb_mirror;
    @(posedge clock) disable iff (srst)
      (!booting && wr_a && !soft_rst && req.wdata[6]) |=> lsb_first;
  endproperty
  a_lsb_mirror: assert property (p_lsb_mirror)
    else $error("lsb first mirror bit ignored");

  property p_asc;
    @(posedge clock) disable iff (srst)
      (!booting && wr_a && !soft_rst)
        |=> addr_incr == $past(req.wdata[2] | req.wdata[5]);
  endproperty
  a_asc: assert property (p_asc)
    else $error("address direction not taken from write");

  property p_dp_rst;
    @(posedge clock) disable iff (srst)
      (!booting && wr_b && req.wdata[1]) |=> dp_soft_rst_q ##1 !dp_soft_rst_q
        || (wr_b && req.wdata[1]);
  endproperty
  a_dp_rst: assert property (p_dp_rst)
    else $error("datapath reset pulse wrong");

  property p_pwr_down;
    @(posedge clock) disable iff (srst)
      pwr_a == 2'h3 |-> !ch_a_ctl.clk_en && ch_a_ctl.dp_rst
                        && !ch_a_ctl.link_en;
  endproperty
  a_pwr_down: assert property (p_pwr_down)
    else $error("power-down controls wrong");

  property p_both_write;
    @(posedge clock) disable iff (srst)
      (!booting && wr_pwr && ch_sel_q == 2'h3)
        |=> pwr_a == $past(req.wdata[1:0]) && pwr_b == pwr_a;
  endproperty
  a_both_write: assert property (p_both_write)
    else $error("write did not reach both channels");

  property p_read_a;
    @(posedge clock) disable iff (srst)
      (req.rd && req.addr == `SCRR_ADDR_PWR && ch_sel_q == 2'h3)
        |=> rdata_q == {6'h00, $past(pwr_a)} && rvalid_q;
  endproperty
  a_read_a: assert property (p_read_a)
    else $error("dual select read did not return channel A");

  property p_cfg_b_zero;
    @(posedge clock) disable iff (srst)
      (req.rd && req.addr == `SCRR_ADDR_CFG_B) |=> rdata_q == 8'h00;
  endproperty
  a_cfg_b_zero: assert property (p_cfg_b_zero)
    else $error("self-clearing or reserved bits read nonzero");
endmodule
`default_nettype wire

// *** scrr_host.sv ***
// host model that issues register requests to the bank
`timescale 1ns/100ps
`default_nettype none
module scrr_host
(
  // clock
  input  wire logic          clock,
  // request and answer
  output var scrr_pkg::scrr_req_t req,
  input  wire logic [7:0]    rdata_q,
  input  wire logic          rvalid_q,
  input  wire logic          booting
);
  initial req = '0;

  // only mapped addresses are ever written
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clock);
    // released lines must not keep the old byte
    #1 req = '{1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic rd(input logic [14:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clock);
    #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    #1 req = '{1'b0, 1'b0, ~a, 8'hA5};
    v = rvalid_q;
    d = rdata_q;
  endtask

  // no write until the defaults have reloaded
  task automatic wait_boot(output int n);
    n = 0;
    while (booting !== 1'b0 && n < 100)
    begin
      @(posedge clock);
      #1 n++;
    end
  endtask
endmodule
`default_nettype wire

// *** scrr_regs_tb.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
`include "scrr_defines.svh"
module scrr_regs_tb;
  localparam int BC = 8;
  logic                   clock;
  logic                   srst;
  scrr_pkg::scrr_req_t    req;
  logic [7:0]             rdata_q;
  logic                   rvalid_q, lsb_first, addr_incr;
  logic                   port_rst_q, booting, dp_soft_rst_q;
  scrr_pkg::scrr_ch_ctl_t ch_a_ctl, ch_b_ctl;
  int                     n_mismatch, compares, n;

  scrr_regs #(.BOOT_CYC(BC)) dut (.clock(clock), .srst(srst), .req(req),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .lsb_first(lsb_first),
    .addr_incr(addr_incr), .port_rst_q(port_rst_q), .booting(booting),
    .dp_soft_rst_q(dp_soft_rst_q), .ch_a_ctl(ch_a_ctl),
    .ch_b_ctl(ch_b_ctl));
  scrr_host host (.clock(clock), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .booting(booting));

  // ----------------------------------------
  // compare helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkc(input scrr_pkg::scrr_ch_ctl_t got,
                      input logic [2:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t ctl %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk(`SCRR_ADDR_CFG_A, 8'h00);
    rdchk(`SCRR_ADDR_CFG_B, 8'h00);
    rdchk(`SCRR_ADDR_PWR, 8'h00);
    rdchk(`SCRR_ADDR_CH_SEL, 8'h03);
    rdchk(15'h0013, 8'h00);
    chkc(ch_a_ctl, 3'b101);
  endtask

  task automatic t_order;
    host.wr(`SCRR_ADDR_CFG_A, 8'h02);
    chk({7'h00, lsb_first}, 8'h01);
    rdchk(`SCRR_ADDR_CFG_A, 8'h42);
    host.wr(`SCRR_ADDR_CFG_A, 8'h20);
    chk({6'h00, addr_incr, lsb_first}, 8'h02);
    rdchk(`SCRR_ADDR_CFG_A, 8'h24);
    host.wr(`SCRR_ADDR_CFG_A, 8'h18);
    rdchk(`SCRR_ADDR_CFG_A, 8'h00);
  endtask

  task automatic t_dp;
    host.wr(`SCRR_ADDR_CFG_B, 8'hFF);
    chk({6'h00, dp_soft_rst_q, port_rst_q}, 8'h02);
    @(posedge clock);
    #1 chk({7'h00, dp_soft_rst_q}, 8'h00);
    rdchk(`SCRR_ADDR_CFG_B, 8'h00);
  endtask

  task automatic t_power;
    logic [1:0] c [3] = '{2'h0, 2'h2, 2'h3};
    logic [2:0] e [3] = '{3'b101, 3'b001, 3'b010};
    host.wr(`SCRR_ADDR_CH_SEL, 8'h01);
    foreach (c[i])
    begin
      host.wr(`SCRR_ADDR_PWR, {6'h3F, c[i]});
      chkc(ch_a_ctl, e[i]);
      chkc(ch_b_ctl, 3'b101);
      rdchk(`SCRR_ADDR_PWR, {6'h00, c[i]});
    end
    host.wr(`SCRR_ADDR_CH_SEL, 8'h02);
    host.wr(`SCRR_ADDR_PWR, 8'h02);
    chkc(ch_b_ctl, 3'b001);
    host.wr(`SCRR_ADDR_CH_SEL, 8'h03);
    rdchk(`SCRR_ADDR_PWR, 8'h03);
    host.wr(`SCRR_ADDR_PWR, 8'h00);
    chkc(ch_a_ctl, 3'b101);
    chkc(ch_b_ctl, 3'b101);
  endtask

  task automatic t_soft;
    logic [7:0] s [2] = '{8'h01, 8'h80};
    foreach (s[i])
    begin
      host.wr(`SCRR_ADDR_CFG_A, 8'h02);
      host.wr(`SCRR_ADDR_CH_SEL, 8'h01);
      host.wr(`SCRR_ADDR_PWR, 8'h03);
      host.wr(`SCRR_ADDR_CFG_A, s[i]);
      chk({5'h00, port_rst_q, booting, lsb_first}, 8'h06);
      // a write during reload must be dropped
      host.wr(`SCRR_ADDR_CFG_A, 8'h02);
      host.wait_boot(n);
      chk({7'h00, n <= BC}, 8'h01);
      rdchk(`SCRR_ADDR_CFG_A, 8'h00);
      rdchk(`SCRR_ADDR_PWR, 8'h00);
      rdchk(`SCRR_ADDR_CH_SEL, 8'h03);
    end
  endtask

  task automatic print_verdict;
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    srst = 1'b1;
    n_mismatch = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    #1 srst = 1'b0;
    host.wait_boot(n);
    chk({7'h00, n <= BC}, 8'h01);
    t_reset;
    t_order;
    t_dp;
    t_power;
    t_soft;
    print_verdict;
  end

  // whole run is little more than a hundred cycles
  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
endmodule
`default_nettype wire
